// File: inc/cww_pkg.sv
// Package for the capture window width register block.
// Holds byte offsets, status codes, step sizes, interrupt layout and register indices.
package cww_pkg;
    // Printed byte offsets, not all multiples of four: kept as indices
    localparam logic [3:0]  IDX_STATUS    = 4'h0;
    localparam logic [3:0]  IDX_WIDTH     = 4'h1;
    localparam logic [3:0]  IDX_MINIMUM   = 4'h3;
    localparam logic [3:0]  IDX_MAXIMUM   = 4'h5;
    localparam logic [3:0]  IDX_STEP      = 4'h7;
    localparam logic [3:0]  IDX_CONFIG    = 4'h8;
    localparam logic [3:0]  IDX_IRQ_STAT  = 4'h9;
    localparam logic [3:0]  IDX_IRQ_MASK  = 4'hA;
    localparam logic [3:0]  IDX_START_COL = 4'hB;
    localparam int          ADDR_W        = 6;

    // Status codes
    localparam logic [7:0]  ST_ABSENT     = 8'h00;
    localparam logic [7:0]  ST_OK         = 8'h01;
    localparam logic [7:0]  ST_RANGE      = 8'h80;
    localparam logic [7:0]  ST_CONFLICT   = 8'h81;

    // Step sizes
    localparam logic [15:0] STEP_NORMAL   = 16'h0010;
    localparam logic [15:0] STEP_HIGHRES  = 16'h0050;

    // Config register fields
    localparam int          CFG_PRESENT   = 0;
    localparam int          CFG_HIGHRES   = 1;

    // Interrupt bits
    localparam int          IRQ_RANGE     = 0;
    localparam int          IRQ_CONFLICT  = 1;
    localparam int          IRQ_CHANGE    = 2;
    localparam int          IRQ_W         = 3;

    // Reset values
    localparam logic [15:0] RST_WIDTH     = 16'h0010;
    localparam logic [15:0] RST_START_COL = 16'h0000;
    localparam logic [1:0]  RST_CONFIG    = 2'h1;

    // Bus answer timing: waitrequest low one cycle after request
    localparam int          BUS_WAIT      = 1;
endpackage : cww_pkg

// File: src/cww_csr.sv
// Capture window width control and status register block.
// Avalon-MM slave, one aligned word per printed offset (byte address = 4 x index).
//
// Summary of operation
// RULE1 - Status reads zero when the width control is absent.
// RULE2 - Status reads one when present and all related settings valid.
// RULE3 - Status reads 0x80 when any value here is out of range.
// RULE4 - Status reads 0x81 when start column and width conflict.
// RULE5 - Writing the width field sets the window width in columns.
// RULE6 - Normal variants accept widths only in steps of 16.
// RULE7 - High resolution variant accepts widths only in steps of 80.
// RULE8 - Allowed range narrows with related settings such as start column.
// RULE9 - Width is two bytes, low byte at lower location.
// RULE10 - Min and max fields report legal width, recomputed on setting changes.
// RULE11 - Step field reports the increment widths must follow.
// RULE12 - Width below min, above max, or off step reports out of range. Above max but within SENSOR_COLS, with a nonzero start column, reads 0x81 here.
`timescale 1ns/1ns
`default_nettype none
module cww_csr
    import cww_pkg::*;
#(
    parameter int SENSOR_COLS = 2048
) (
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              rst,
    // Avalon-MM slave
    input  wire logic [ADDR_W-1:0] avs_address,
    input  wire logic              avs_read,
    input  wire logic              avs_write,
    input  wire logic [31:0]       avs_writedata,
    input  wire logic [3:0]        avs_byteenable,
    output logic      [31:0]       avs_readdata,
    output logic                   avs_waitrequest,
    output logic      [1:0]        avs_response,
    // Window settings to the sensor path
    output logic      [15:0]       window_width,
    output logic      [15:0]       window_start_col,
    // Interrupt
    output logic                   irq
);
    typedef enum logic [1:0] {
        CWW_IDLE = 2'b00,
        CWW_ACK  = 2'b01
    } cww_bus_e;

    cww_bus_e          bus_q;
    cww_bus_e          bus_d;

    logic [15:0]       width_q;
    logic [15:0]       start_q;
    logic [1:0]        cfg_q;
    logic [7:0]        status_q;
    logic [15:0]       min_q;
    logic [15:0]       max_q;
    logic [15:0]       step_q;
    logic [IRQ_W-1:0]  istat_q;
    logic [IRQ_W-1:0]  imask_q;
    logic [31:0]       rdata_q;
    logic              wait_q;
    logic [1:0]        resp_q;
    logic              irq_q;
    logic [15:0]       width_out_q;
    logic [15:0]       start_out_q;

    wire logic [15:0]  min_c;
    wire logic [15:0]  max_c;
    wire logic [15:0]  step_c;
    wire logic         range_c;
    wire logic         conflict_c;
    wire logic         bad_range;
    wire logic [7:0]   status_c;

    wire logic [3:0]   idx;
    wire logic         word_ok;
    wire logic         req;
    wire logic         accept;
    wire logic         hit_status;
    wire logic         hit_width;
    wire logic         hit_min;
    wire logic         hit_max;
    wire logic         hit_step;
    wire logic         hit_cfg;
    wire logic         hit_istat;
    wire logic         hit_imask;
    wire logic         hit_start;
    wire logic         mapped;
    wire logic         wr;
    wire logic [31:0]  rdata_c;
    wire logic [15:0]  width_d;
    wire logic [15:0]  start_d;
    wire logic [1:0]   cfg_d;
    wire logic [IRQ_W-1:0] imask_d;
    wire logic [IRQ_W-1:0] ievent;
    wire logic [IRQ_W-1:0] iclear;
    wire logic         limits_changed;

    // Bus decode
    assign idx        = avs_address[ADDR_W-1:2];
    assign word_ok    = (avs_address[1:0] == 2'b00);
    assign req        = (avs_read || avs_write) && (bus_q == CWW_IDLE);
    assign accept     = req;
    assign hit_status = word_ok && (idx == IDX_STATUS);
    assign hit_width  = word_ok && (idx == IDX_WIDTH);
    assign hit_min    = word_ok && (idx == IDX_MINIMUM);
    assign hit_max    = word_ok && (idx == IDX_MAXIMUM);
    assign hit_step   = word_ok && (idx == IDX_STEP);
    assign hit_cfg    = word_ok && (idx == IDX_CONFIG);
    assign hit_istat  = word_ok && (idx == IDX_IRQ_STAT);
    assign hit_imask  = word_ok && (idx == IDX_IRQ_MASK);
    assign hit_start  = word_ok && (idx == IDX_START_COL);
    assign mapped     = hit_status || hit_width || hit_min || hit_max || hit_step
                      || hit_cfg || hit_istat || hit_imask || hit_start;
    assign wr         = accept && avs_write;

    // Byte lanes: low byte of a 16-bit field in lane 0
    assign width_d = {(wr && hit_width && avs_byteenable[1]) ? avs_writedata[15:8] : width_q[15:8],
                      (wr && hit_width && avs_byteenable[0]) ? avs_writedata[7:0]  : width_q[7:0]}; // RULE5 RULE9
    assign start_d = {(wr && hit_start && avs_byteenable[1]) ? avs_writedata[15:8] : start_q[15:8],
                      (wr && hit_start && avs_byteenable[0]) ? avs_writedata[7:0]  : start_q[7:0]};
    assign cfg_d   = (wr && hit_cfg && avs_byteenable[0]) ? avs_writedata[1:0] : cfg_q;
    assign imask_d = (wr && hit_imask && avs_byteenable[0]) ? avs_writedata[IRQ_W-1:0] : imask_q;
    assign iclear  = (wr && hit_istat && avs_byteenable[0]) ? avs_writedata[IRQ_W-1:0] : '0;

    // Limits follow the currently stored settings
    cww_limits #(
        .SENSOR_COLS (SENSOR_COLS)
    ) u_limits (
        .highres      (cfg_q[CFG_HIGHRES]),
        .start_col    (start_q),
        .width        (width_q),
        .min_w        (min_c),
        .max_w        (max_c),
        .step_w       (step_c),
        .out_of_range (range_c),
        .conflict     (conflict_c)
    ); // RULE6 RULE7 RULE8

    // Out of range against minimum, step and SENSOR_COLS; against maximum only at start column 0
    assign bad_range = range_c || (width_q > max_c && !conflict_c && start_q == 16'h0000); // RULE12

    assign status_c = !cfg_q[CFG_PRESENT] ? ST_ABSENT :            // RULE1
                      bad_range           ? ST_RANGE :             // RULE3
                      conflict_c          ? ST_CONFLICT :          // RULE4
                                            ST_OK;                 // RULE2

    // Events raised on entering an error code or on limit change
    assign limits_changed = (min_c != min_q) || (max_c != max_q) || (step_c != step_q);
    assign ievent[IRQ_RANGE]    = (status_c == ST_RANGE) && (status_q != ST_RANGE);
    assign ievent[IRQ_CONFLICT] = (status_c == ST_CONFLICT) && (status_q != ST_CONFLICT);
    assign ievent[IRQ_CHANGE]   = limits_changed;

    // Read mux
    assign rdata_c = hit_status ? {24'h000000, status_q} :
                     hit_width  ? {16'h0000, width_q} :                     // RULE9
                     hit_min    ? {16'h0000, min_q} :                       // RULE10
                     hit_max    ? {16'h0000, max_q} :                       // RULE10
                     hit_step   ? {16'h0000, step_q} :                      // RULE11
                     hit_cfg    ? {30'h0, cfg_q} :
                     hit_istat  ? {29'h0, istat_q} :
                     hit_imask  ? {29'h0, imask_q} :
                     hit_start  ? {16'h0000, start_q} :
                                  32'h00000000;

    // Handshake: one wait cycle then release
    always_comb begin
        bus_d = bus_q;
        case (bus_q)
            CWW_IDLE: begin
                if (req) begin
                    bus_d = CWW_ACK;
                end
            end
            CWW_ACK: begin
                bus_d = CWW_IDLE;
            end
            default: begin
                bus_d = CWW_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            bus_q   <= CWW_IDLE;
            wait_q  <= 1'b1;
            rdata_q <= 32'h00000000;
            resp_q  <= 2'b00;
        end else begin
            bus_q   <= bus_d;
            wait_q  <= !(req);
            rdata_q <= (accept && avs_read) ? rdata_c : 32'h00000000;
            resp_q  <= (accept && !mapped) ? 2'b11 : 2'b00;
        end
    end

    // Settings
    always_ff @(posedge clk) begin
        if (rst) begin
            width_q <= RST_WIDTH;
            start_q <= RST_START_COL;
            cfg_q   <= RST_CONFIG;
            imask_q <= '0;
        end else begin
            width_q <= width_d; // RULE5
            start_q <= start_d;
            cfg_q   <= cfg_d;
            imask_q <= imask_d;
        end
    end

    // Status and limits, recomputed each cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            status_q <= ST_ABSENT;
            min_q    <= STEP_NORMAL;
            max_q    <= STEP_NORMAL;
            step_q   <= STEP_NORMAL;
        end else begin
            status_q <= status_c; // RULE1 RULE2 RULE3 RULE4
            min_q    <= min_c;    // RULE10
            max_q    <= max_c;    // RULE10
            step_q   <= step_c;   // RULE11
        end
    end

    // Sticky interrupt status: set wins over clear
    always_ff @(posedge clk) begin
        if (rst) begin
            istat_q <= '0;
            irq_q   <= 1'b0;
        end else begin
            istat_q <= (istat_q & ~iclear) | ievent;
            irq_q   <= |(((istat_q & ~iclear) | ievent) & imask_q);
        end
    end

    // Registered outputs
    always_ff @(posedge clk) begin
        if (rst) begin
            width_out_q <= RST_WIDTH;
            start_out_q <= RST_START_COL;
        end else begin
            width_out_q <= width_q;
            start_out_q <= start_q;
        end
    end

    assign avs_readdata     = rdata_q;
    assign avs_waitrequest  = wait_q;
    assign avs_response     = resp_q;
    assign window_width     = width_out_q;
    assign window_start_col = start_out_q;
    assign irq              = irq_q;
endmodule : cww_csr
`default_nettype wire

// File: src/cww_limits.sv
// Limit calculator for the capture window width.
// Purely combinational; the parent registers all results.
`timescale 1ns/1ns
`default_nettype none
module cww_limits
    import cww_pkg::*;
#(
    parameter int SENSOR_COLS = 2048
) (
    // Related settings
    input  wire logic        highres,
    input  wire logic [15:0] start_col,
    input  wire logic [15:0] width,
    // Limits
    output wire logic [15:0] min_w,
    output wire logic [15:0] max_w,
    output wire logic [15:0] step_w,
    // Checks
    output wire logic        out_of_range,
    output wire logic        conflict
);
    localparam logic [16:0] COLS = 17'(SENSOR_COLS);

    wire logic [16:0] room;
    wire logic [15:0] step_mod;
    wire logic [16:0] span_end;

    assign step_w   = highres ? STEP_HIGHRES : STEP_NORMAL;
    assign min_w    = step_w;
    // Largest multiple of the step fitting in the sensor beyond the start column
    assign room     = (start_col < COLS[15:0]) ? (COLS - {1'b0, start_col}) : 17'h00000;
    assign max_w    = 16'(room[15:0] - (room[15:0] % step_w));
    assign step_mod = width % step_w;
    assign span_end = {1'b0, start_col} + {1'b0, width};
    assign out_of_range = (width < min_w) || (step_mod != 16'h0000)
                        || ({1'b0, width} > COLS);
    assign conflict = !out_of_range && (span_end > COLS);
endmodule : cww_limits
`default_nettype wire

// File: tb/cww_csr_properties.sv
// Assertions on the capture window width register block ports.
// Assumes the one-wait Avalon-MM answer of the block.
`timescale 1ns/1ns
`default_nettype none
module cww_properties
    import cww_pkg::*;
(
    // Clock and reset
    input wire logic              clk,
    input wire logic              rst,
    // Bus
    input wire logic [ADDR_W-1:0] avs_address,
    input wire logic              avs_read,
    input wire logic              avs_write,
    input wire logic [31:0]       avs_writedata,
    input wire logic [3:0]        avs_byteenable,
    input wire logic [31:0]       avs_readdata,
    input wire logic              avs_waitrequest,
    input wire logic [1:0]        avs_response,
    // Settings and interrupt
    input wire logic [15:0]       window_width,
    input wire logic [15:0]       window_start_col,
    input wire logic              irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    chk_wait_one_cycle: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low longer than one cycle");
    chk_answer_has_request: assert property (!avs_waitrequest |-> $past(avs_read || avs_write))
        else $error("answer without request");
    chk_request_answered: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("request not answered after one wait");
    chk_resp_with_answer: assert property (avs_response != 2'b00 |-> !avs_waitrequest)
        else $error("response outside answer");
    chk_idle_data_zero: assert property (avs_waitrequest |-> avs_readdata == 32'h0000_0000)
        else $error("read data outside answer");
    chk_misaligned_error: assert property ((avs_read || avs_write) && avs_waitrequest
        && avs_address[1:0] != 2'b00 |=> avs_response == 2'b11)
        else $error("misaligned access not refused");
    chk_width_by_write: assert property ($changed(window_width) |->
        $past(avs_write, 2) && $past(avs_address, 2) == {IDX_WIDTH, 2'b00})
        else $error("window width changed without write");
    chk_start_by_write: assert property ($changed(window_start_col) |->
        $past(avs_write, 2) && $past(avs_address, 2) == {IDX_START_COL, 2'b00})
        else $error("start column changed without write");
    chk_status_mapped: assert property (!avs_waitrequest && $past(avs_address) == {IDX_STATUS, 2'b00}
        |-> avs_response == 2'b00)
        else $error("status access refused");
endmodule : cww_properties
bind cww_csr cww_properties cww_properties_inst (.clk(clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .avs_response(avs_response), .window_width(window_width), .window_start_col(window_start_col),
    .irq(irq));
`default_nettype wire

// File: tb/cww_csr_test.sv
// Testbench for the capture window width register block.
// Drives the Avalon-MM port itself; no partner model.
`timescale 1ns/1ns
`default_nettype none
module cww_csr_test
    import cww_pkg::*;
();
    localparam int SC = 2048;
    logic        clk;
    logic        rst;
    logic [5:0]  adr;
    logic        rd_r;
    logic        wr_r;
    logic [31:0] wd;
    logic [3:0]  be;
    wire  [31:0] rdata;
    wire         wreq;
    wire  [1:0]  resp;
    wire  [15:0] ww;
    wire  [15:0] wsc;
    wire         irq;
    int          n_mismatch = 0;
    int          comparisons = 0;
    int          cycles = 0;
    logic [31:0] seed = 32'h3F7437E8;
    logic [31:0] q;
    logic [1:0]  rs;
    logic        wreq_s;
    logic [31:0] rdata_s;
    logic [1:0]  resp_s;
    logic [15:0] ww_s;
    logic [15:0] wsc_s;
    logic        irq_s;
    logic [1:0]  lo = 2'b00;
    cww_csr #(.SENSOR_COLS(SC)) cww_csr_inst (.clk(clk), .rst(rst), .avs_address(adr), .avs_read(rd_r),
        .avs_write(wr_r), .avs_writedata(wd), .avs_byteenable(be), .avs_readdata(rdata),
        .avs_waitrequest(wreq), .avs_response(resp), .window_width(ww), .window_start_col(wsc), .irq(irq));
    // Outputs taken at the falling edge, settled for the next rising edge
    always @(negedge clk) begin
        wreq_s  <= wreq;
        rdata_s <= rdata;
        resp_s  <= resp;
        ww_s    <= ww;
        wsc_s   <= wsc;
        irq_s   <= irq;
    end
    function automatic logic [31:0] lfsr(logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr
    function automatic logic [7:0] exp_st(logic [1:0] c, logic [15:0] s, logic [15:0] w);
        logic [15:0] st;
        st = c[1] ? STEP_HIGHRES : STEP_NORMAL;
        if (!c[0]) return ST_ABSENT;
        if (w < st || w % st != 0 || w > SC) return ST_RANGE;
        if (s + w > SC) return ST_CONFLICT;
        return ST_OK;
    endfunction : exp_st
    task automatic conclude();
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : conclude
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (e !== g) begin
            n_mismatch++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // One access, held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [3:0] i, input logic [31:0] d, input logic [3:0] b);
        @(posedge clk);
        adr <= {i, lo};
        wd <= d;
        be <= b;
        wr_r <= w;
        rd_r <= !w;
        do @(posedge clk); while (wreq_s !== 1'b0);
        q = rdata_s;
        rs = resp_s;
        wr_r <= 1'b0;
        rd_r <= 1'b0;
    endtask : bus
    task automatic trial(input logic [1:0] c, input logic [15:0] s, input logic [15:0] w);
        logic [15:0] st;
        st = c[1] ? STEP_HIGHRES : STEP_NORMAL;
        bus(1, IDX_CONFIG, {30'h0, c}, 4'hF);
        bus(1, IDX_START_COL, {16'h0, s}, 4'hF);
        bus(1, IDX_WIDTH, {16'hFFFF, w}, 4'h3);
        bus(0, IDX_WIDTH, 0, 4'hF);
        chk("width", w, q[15:0]);
        chk("window_width", w, ww_s);
        chk("start_col", s, wsc_s);
        bus(0, IDX_STATUS, 0, 4'hF);
        chk("status", exp_st(c, s, w), q[7:0]);
        if (c[0]) begin
            bus(0, IDX_MINIMUM, 0, 4'hF);
            chk("minimum", st, q[15:0]);
            bus(0, IDX_MAXIMUM, 0, 4'hF);
            chk("maximum", (SC - s) / st * st, q[15:0]);
            bus(0, IDX_STEP, 0, 4'hF);
            chk("step", st, q[15:0]);
        end
    endtask : trial
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_mismatch++;
            conclude();
        end
    end
    initial begin
        rst = 1'b1;
        adr = 6'h00;
        rd_r = 1'b0;
        wr_r = 1'b0;
        wd = 32'h0;
        be = 4'h0;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        bus(0, IDX_STATUS, 0, 4'hF);
        chk("reset status", ST_OK, q[7:0]);
        chk("reset width", RST_WIDTH, ww_s);
        // Byte lanes: high byte alone
        bus(1, IDX_WIDTH, 32'h0000_12AB, 4'hF);
        bus(1, IDX_WIDTH, 32'h0000_34CD, 4'h2);
        bus(0, IDX_WIDTH, 0, 4'hF);
        chk("width lanes", 16'h34AB, q[15:0]);
        // Refused and read-only places
        bus(0, 4'h2, 0, 4'hF);
        chk("unmapped resp", 2'b11, rs);
        chk("unmapped data", 0, q);
        // Misaligned write refused and dropped
        lo = 2'b01;
        bus(1, IDX_WIDTH, 32'h0000_0020, 4'hF);
        chk("misaligned resp", 2'b11, rs);
        lo = 2'b00;
        bus(0, IDX_WIDTH, 0, 4'hF);
        chk("misaligned drop", 16'h34AB, q[15:0]);
        bus(1, IDX_STEP, 32'h0000_FFFF, 4'hF);
        bus(0, IDX_STEP, 0, 4'hF);
        chk("step read only", STEP_NORMAL, q[15:0]);
        // Interrupt: legal width first so that the range code is entered anew
        bus(1, IDX_WIDTH, 32'h0000_0010, 4'hF);
        bus(1, IDX_IRQ_STAT, 32'h7, 4'hF);
        bus(1, IDX_IRQ_MASK, 32'h0, 4'hF);
        trial(2'b01, 16'd0, 16'd17);
        bus(0, IDX_IRQ_STAT, 0, 4'hF);
        chk("irq status", 1'b1, q[IRQ_RANGE]);
        chk("irq masked", 1'b0, irq_s);
        bus(1, IDX_IRQ_MASK, 32'h1, 4'hF);
        bus(0, IDX_STATUS, 0, 4'hF);
        chk("irq raised", 1'b1, irq_s);
        bus(1, IDX_IRQ_STAT, 32'h1, 4'hF);
        bus(0, IDX_STATUS, 0, 4'hF);
        chk("irq cleared", 1'b0, irq_s);
        trial(2'b01, 16'd0, 16'd0);
        trial(2'b01, 16'd0, 16'd2048);
        trial(2'b01, 16'd0, 16'd2064);
        trial(2'b01, 16'd2032, 16'd16);
        trial(2'b01, 16'd2032, 16'd32);
        trial(2'b00, 16'd0, 16'd64);
        trial(2'b11, 16'd0, 16'd2000);
        trial(2'b11, 16'd80, 16'd2000);
        trial(2'b11, 16'd0, 16'd96);
        for (int i = 0; i < 24; i++) begin
            seed = lfsr(seed);
            trial({seed[31], 1'b1}, {5'h0, seed[26:20], 4'h0}, seed[12] ? {4'h0, seed[11:0]}
                : {5'h0, seed[10:4], 4'h0});
        end
        conclude();
    end
endmodule : cww_csr_test
`default_nettype wire
